// ---- design/nvs_pkg.sv ----
// package for the nvram supervisor: timing constants and carrier structs
// assumes a single 200 MHz clock and digitised comparator inputs
// Behaviour
// - good settled supply passes select through decode
// - supply below threshold forces all selects high
// - threshold pick input chooses comparator threshold
// - access in progress finishes before blocking
// - protect deadline expiry forces selects high
// - backup source below switchover, main above
// - selects held inactive for recovery time
// - two-bit decode drives one select low
// - reset asserted within protect deadline
// - reset held low for hold time after rise
// - battery tested at power-up and periodically
// - weak flag set when test fails
// - weak flag stays until a test passes
// - battery tests only with main supply present
package nvs_pkg;
    localparam int CLK_MHZ = 200;
    localparam int PROTECT_US = 150;
    localparam int RECOVERY_MS = 120;
    localparam int HOLD_MS = 200;
    localparam int TEST_HOURS = 24;
    localparam int PROTECT_CYC = PROTECT_US * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_MS * 1000 * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
    localparam longint TEST_CYC = longint'(TEST_HOURS) * 3600 * 1000000
        * CLK_MHZ;
    localparam logic [3:0] SEL_IDLE = 4'hF;
    localparam logic [3:0] SEL_ONE = 4'h1;

    // digitised comparator results
    typedef struct packed {
        logic above_fail_hi; // supply above high threshold
        logic above_fail_lo; // supply above low threshold
        logic above_switch;  // supply above switchover level
        logic batt_ok;       // battery above weak level
    } nvs_sense_t;

    // host select request
    typedef struct packed {
        logic cs_b;
        logic [1:0] decode;
    } nvs_sel_t;
endpackage : nvs_pkg

// ---- design/nvs_sync.sv ----
// two flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module nvs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // stage one feeds only stage two
    always_comb
    begin
        s1_nxt = d;
        q_nxt = s1_r;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r <= '0;
            q_r <= '0;
        end
        else
        begin
            s1_r <= s1_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : nvs_sync
`default_nettype wire

// ---- design/nvs_timer.sv ----
// restartable down counter that flags when its interval has elapsed
// assumes start and run come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
module nvs_timer #(
    parameter int W = 32,
    parameter longint LOAD = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic run,
    output logic done
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    initial
    begin
        if (LOAD < 1 || LOAD >= (longint'(1) << W))
            $error("nvs_timer load does not fit");
    end

    // load on start, count while run, flag at zero
    always_comb
    begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (start)
        begin
            cnt_nxt = W'(LOAD - 1);
            done_nxt = 1'b0;
        end
        else if (run && !done_r)
        begin
            if (cnt_r == '0)
                done_nxt = 1'b1;
            else
                cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : nvs_timer
`default_nettype wire

// ---- design/nvs_supervisor.sv ----
// nvram supervisor: select gating, power-on reset, battery monitor
// assumes comparator results arrive as asynchronous digital levels
`timescale 1ns/1ps
`default_nettype none
module nvs_supervisor
    import nvs_pkg::*;
#(
    parameter int PROTECT_CYCLES = PROTECT_CYC,
    parameter int RECOVERY_CYCLES = RECOVERY_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter longint TEST_CYCLES = TEST_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire nvs_pkg::nvs_sense_t sense_in,
    input wire logic threshold_pick,
    input wire nvs_pkg::nvs_sel_t sel_in,
    output logic [3:0] gated_select_out_b,
    output logic backed_supply_from_batt,
    output logic reset_out_b_o,
    output logic reset_out_b_oe,
    output logic battery_weak_flag_b_o,
    output logic battery_weak_flag_b_oe
);
    nvs_sense_t sense;
    nvs_sel_t sel;
    logic thr_pick;

    initial
    begin
        if (PROTECT_CYCLES < 1 || RECOVERY_CYCLES < 1 || HOLD_CYCLES < 1
            || TEST_CYCLES < 1)
            $error("nvs_supervisor durations must be positive");
    end

    // synchronise every pin-level input
    nvs_sync #(.W($bits(nvs_sense_t))) u_sync_sense (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d(sense_in),
        .q(sense)
    );
    nvs_sync #(.W($bits(nvs_sel_t) + 1)) u_sync_sel (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d({sel_in, threshold_pick}),
        .q({sel, thr_pick})
    );

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_RECOVER = 4'h2,
        ST_RUN = 4'h4,
        ST_DRAIN = 4'h8
    } nvs_state_t;

    nvs_state_t state_r;
    nvs_state_t state_nxt;
    logic supply_good;
    logic rec_done;
    logic hold_done;
    logic prot_done;
    logic test_done;
    logic enter_rec;
    logic enter_drain;
    logic [3:0] sel_r;
    logic [3:0] sel_nxt;
    logic rst_low_r;
    logic rst_low_nxt;
    logic weak_r;
    logic weak_nxt;
    logic batt_src_r;
    logic batt_src_nxt;
    logic good_d_r;
    logic good_d_nxt;
    logic [3:0] decoded;

    // threshold chosen by pick level; pick high selects low threshold
    assign supply_good = thr_pick ? sense.above_fail_lo
                                  : sense.above_fail_hi;
    assign enter_rec = supply_good && !good_d_r;
    assign enter_drain = !supply_good && good_d_r;

    // recovery, hold, protect and test intervals
    nvs_timer #(.W(32), .LOAD(RECOVERY_CYCLES)) u_rec (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(enter_rec),
        .run(state_r == ST_RECOVER),
        .done(rec_done)
    );
    nvs_timer #(.W(32), .LOAD(HOLD_CYCLES)) u_hold (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(enter_rec),
        .run(supply_good),
        .done(hold_done)
    );
    nvs_timer #(.W(32), .LOAD(PROTECT_CYCLES)) u_prot (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(enter_drain),
        .run(state_r == ST_DRAIN),
        .done(prot_done)
    );
    nvs_timer #(.W(48), .LOAD(TEST_CYCLES)) u_test (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(enter_rec || test_done),
        .run(supply_good),
        .done(test_done)
    );

    // one-hot low decode of the two select bits
    always_comb
    begin
        decoded = SEL_IDLE;
        if (!sel.cs_b)
            decoded = ~(SEL_ONE << sel.decode);
    end

    // supply state sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF:
                if (supply_good)
                    state_nxt = ST_RECOVER;
            ST_RECOVER:
                if (!supply_good)
                    state_nxt = ST_OFF;
                else if (rec_done)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (!supply_good)
                    state_nxt = (sel_r != SEL_IDLE) ? ST_DRAIN
                                                    : ST_OFF;
            ST_DRAIN:
                if (sel.cs_b || prot_done)
                    state_nxt = ST_OFF;
            default:
                state_nxt = ST_OFF;
        endcase
    end

    // gated selects, reset, battery flag and supply source
    always_comb
    begin
        good_d_nxt = supply_good;
        sel_nxt = SEL_IDLE;
        if (state_r == ST_RUN && supply_good)
            sel_nxt = decoded;
        else if (state_r == ST_RUN && !sel.cs_b)
            sel_nxt = sel_r; // supply just failed: keep access
        else if (state_r == ST_DRAIN && !prot_done && !sel.cs_b)
            sel_nxt = sel_r;
        // stale done from the last power cycle must not release reset
        rst_low_nxt = !supply_good || enter_rec
            || !hold_done;
        batt_src_nxt = !sense.above_switch;
        weak_nxt = weak_r;
        if (supply_good && (enter_rec || test_done))
            weak_nxt = !sense.batt_ok;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_OFF;
            sel_r <= SEL_IDLE;
            rst_low_r <= 1'b1;
            weak_r <= 1'b0;
            batt_src_r <= 1'b1;
            good_d_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            rst_low_r <= rst_low_nxt;
            weak_r <= weak_nxt;
            batt_src_r <= batt_src_nxt;
            good_d_r <= good_d_nxt;
        end
    end

    // open-drain outputs drive only low
    assign gated_select_out_b = sel_r;
    assign backed_supply_from_batt = batt_src_r;
    assign reset_out_b_o = 1'b0;
    assign reset_out_b_oe = rst_low_r;
    assign battery_weak_flag_b_o = 1'b0;
    assign battery_weak_flag_b_oe = weak_r;
endmodule : nvs_supervisor
`default_nettype wire

// ---- bench/nvs_monitor.sv ----
// checker: select gating, reset and battery flag relations
// assumes it is bound to nvs_supervisor
`timescale 1ns/1ps
`default_nettype none
module nvs_monitor
    import nvs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire nvs_pkg::nvs_sense_t sense_in,
    input wire logic threshold_pick,
    input wire nvs_pkg::nvs_sel_t sel_in,
    input wire logic [3:0] gated_select_out_b,
    input wire logic backed_supply_from_batt,
    input wire logic reset_out_b_oe,
    input wire logic battery_weak_flag_b_oe
);
    logic good;
    logic [3:0] want;
    // supply good per picked threshold, expected decode
    assign good = threshold_pick ? sense_in.above_fail_lo
        : sense_in.above_fail_hi;
    assign want = sel_in.cs_b ? 4'hF : ~(4'h1 << sel_in.decode);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_one_low: assert property (
        $countones(~gated_select_out_b) <= 1) else $error("two selects low");
    chk_pass_thru: assert property (
        (good && !reset_out_b_oe && $stable(sel_in))[*4]
        |-> gated_select_out_b == want) else $error("select not passed");
    chk_fail_block: assert property (
        $fell(good) |-> ##[1:12] gated_select_out_b == 4'hF)
        else $error("selects not blocked");
    chk_rst_fast: assert property (
        $fell(good) |-> ##[1:5] reset_out_b_oe) else $error("reset late");
    chk_rst_hold: assert property (
        $rose(good) |-> ##1 reset_out_b_oe[*8]) else $error("reset short");
    chk_recov_hold: assert property (
        $rose(good) |-> gated_select_out_b == 4'hF [*8])
        else $error("select during recovery");
    chk_on_batt: assert property (
        !sense_in.above_switch[*5] |-> backed_supply_from_batt)
        else $error("not on battery");
    chk_no_test: assert property (
        !good[*6] |-> $stable(battery_weak_flag_b_oe))
        else $error("test in backup");
    chk_weak_set: assert property (
        $rose(good) && !sense_in.batt_ok |-> ##[2:8] battery_weak_flag_b_oe)
        else $error("weak flag not set");
endmodule : nvs_monitor
bind nvs_supervisor nvs_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b),
    .sense_in(sense_in), .threshold_pick(threshold_pick),
    .sel_in(sel_in), .gated_select_out_b(gated_select_out_b),
    .backed_supply_from_batt(backed_supply_from_batt),
    .reset_out_b_oe(reset_out_b_oe),
    .battery_weak_flag_b_oe(battery_weak_flag_b_oe));
`default_nettype wire

// ---- bench/nvs_host.sv ----
// host model: presents chip select and decode as one select request
// assumes the bench changes requests after falling edges
`timescale 1ns/1ps
`default_nettype none
module nvs_host
    import nvs_pkg::*;
(
    input wire logic cs_b_req,
    input wire logic [1:0] dec_req,
    output var nvs_pkg::nvs_sel_t sel_in
);
    // request levels go straight to the select pins
    always_comb sel_in = '{cs_b: cs_b_req, decode: dec_req};
endmodule : nvs_host
`default_nettype wire

// ---- bench/nvs_supervisor_tb_top.sv ----
// testbench: drives supply, threshold and host selects, checks outputs
// assumes the supervisor built with shortened timing parameters
`timescale 1ns/1ps
`default_nettype none
module nvs_supervisor_tb_top;
    import nvs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    nvs_sense_t sense_in = 4'hF;
    logic threshold_pick = 1'b0;
    logic cs_b = 1'b1;
    logic [1:0] dec = 2'h0;
    nvs_sel_t sel_in;
    logic [3:0] gsel;
    logic batt, rst_oe, weak_oe;
    logic rst_o, weak_o;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 32'h22a2d923;
    nvs_host host (.cs_b_req(cs_b), .dec_req(dec), .sel_in(sel_in));
    nvs_supervisor #(.PROTECT_CYCLES(5), .RECOVERY_CYCLES(20),
        .HOLD_CYCLES(30), .TEST_CYCLES(100)) uut (.clk_sys(clk_sys),
        .rst_b(rst_b), .sense_in(sense_in), .threshold_pick(threshold_pick),
        .sel_in(sel_in), .gated_select_out_b(gsel),
        .backed_supply_from_batt(batt), .reset_out_b_o(rst_o),
        .reset_out_b_oe(rst_oe), .battery_weak_flag_b_o(weak_o),
        .battery_weak_flag_b_oe(weak_oe));
    // clock and hang limit
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 1000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            n_mismatch = n_mismatch + 1;
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    function automatic logic [3:0] mdl(input int c, input int d);
        return (c != 0) ? 4'hF : ~(4'h1 << d);
    endfunction : mdl
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    // main sequence
    initial
    begin
        tick(2);
        rst_b = 1'b1;
        for (int j = 0; j < 200 && rst_oe !== 1'b0; j++) tick(1);
        check({3'h0, rst_oe}, 4'h0);
        check({3'h0, weak_oe}, 4'h0);
        check({2'h0, rst_o, weak_o}, 4'h0);
        for (int k = 0; k < 13; k++)
        begin
            cs_b = (k < 4) ? 1'b0 : (k == 4 ? 1'b1 : 1'($random(seed)));
            dec = (k < 4) ? k[1:0] : 2'($random(seed));
            tick(4);
            check(gsel, mdl(cs_b, dec));
        end
        cs_b = 1'b0;
        dec = 2'h2;
        threshold_pick = 1'b1;
        tick(4);
        sense_in.above_fail_hi = 1'b0;
        tick(6);
        check(gsel, mdl(0, 2));
        threshold_pick = 1'b0;
        tick(4);
        check(gsel, mdl(0, 2));
        tick(8);
        check(gsel, 4'hF);
        check({3'h0, rst_oe}, 4'h1);
        cs_b = 1'b1;
        tick(2);
        cs_b = 1'b0;
        dec = 2'h1;
        tick(4);
        check(gsel, 4'hF);
        sense_in.batt_ok = 1'b0;
        sense_in.above_switch = 1'b0;
        tick(6);
        check({3'h0, batt}, 4'h1);
        sense_in.above_switch = 1'b1;
        sense_in.above_fail_hi = 1'b1;
        tick(5);
        check({3'h0, batt}, 4'h0);
        check(gsel, 4'hF);
        check({3'h0, weak_oe}, 4'h1);
        sense_in.batt_ok = 1'b1;
        tick(23);
        check(gsel, mdl(0, 1));
        check({3'h0, rst_oe}, 4'h1);
        check({3'h0, weak_oe}, 4'h1);
        tick(102);
        check({3'h0, weak_oe}, 4'h0);
        check({3'h0, rst_oe}, 4'h0);
        test_done();
    end
endmodule : nvs_supervisor_tb_top
`default_nettype wire
